// File: pkg/gpc_pkg.sv
package gpc_pkg;

  // Channel count and grayscale width.
  localparam int unsigned CHANNELS   = 16;
  localparam int unsigned GRAY_WIDTH = 12;

  // Counter bounds.
  localparam logic [11:0] COUNT_ZERO = 12'h000;
  localparam logic [11:0] COUNT_ONE  = 12'h001;
  localparam logic [11:0] COUNT_LAST = 12'hfff;
  localparam logic [11:0] GRAY_OFF   = 12'h000;

  // Reset value of the channel outputs.
  localparam logic [15:0] OUTPUTS_OFF = 16'h0000;

  // Synchroniser stage count for pin inputs.
  localparam int unsigned SYNC_STAGES = 2;

  // Cycle phases of the grayscale engine.
  typedef enum logic [1:0] {
    GPC_BLANKED,
    GPC_ARMED,
    GPC_COUNTING,
    GPC_DONE
  } gpc_phase_type;

endpackage

// File: rtl/gpc_sync.sv
`timescale 1ns/1ps
module gpc_sync (
  // Clock, reset and enable.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Asynchronous pin in, synchronised level out.
  input  wire logic i_async,
  output logic      o_sync
);

  // Two-stage chain; only the second stage is read outside.
  logic [gpc_pkg::SYNC_STAGES-1:0] stage;

  // Shift the pin level through both stages.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      stage <= '0;
    else if (i_ce)
      stage <= {stage[0], i_async};
  end

  // Only the last stage leaves the module.
  assign o_sync = stage[gpc_pkg::SYNC_STAGES-1];

endmodule // gpc_sync

// File: rtl/gpc_engine.sv
`timescale 1ns/1ps
module gpc_engine (
  // Clock, reset and enable.
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // Pins from the display controller.
  input  wire logic        i_pwm_count_clock,
  input  wire logic        i_blank,
  input  wire logic        i_latch_strobe,
  // Grayscale values, channel n at bits 12n+11 to 12n.
  input  wire logic [191:0] i_channel_gray_value,
  // Channel sink enables and counter view.
  output logic [15:0]      o_channel_sink_output,
  output logic [11:0]      o_gray_count,
  output logic             o_cycle_done
);

  // Synchronised pin levels.
  logic gclk_s;
  logic blank_s;
  logic latch_s;

  // Whole state of the engine.
  typedef struct packed {
    gpc_pkg::gpc_phase_type          phase;
    logic                            gclk_q;
    logic                            latch_q;
    logic [gpc_pkg::SYNC_STAGES-1:0] settle;
    logic [11:0]                     count;
    logic [191:0]                    gray;
    logic [15:0]                     sink;
    logic                            done;
  } gpc_state_type;

  gpc_state_type st;
  gpc_state_type next_st;

  // Picks one channel's grayscale value out of a packed vector.
  function automatic logic [11:0] gray_of(input logic [191:0] v, input int unsigned ch);
    gray_of = v[ch*gpc_pkg::GRAY_WIDTH +: gpc_pkg::GRAY_WIDTH];
  endfunction

  // Per-channel compare results and the counter value one pulse ahead.
  logic [gpc_pkg::CHANNELS-1:0] chan_lit;
  logic [gpc_pkg::CHANNELS-1:0] chan_hit_now;
  logic [gpc_pkg::CHANNELS-1:0] chan_hit_inc;
  logic [11:0]                  cnt_inc;

  // Counter value after one more pulse; it never wraps, the top value stops counting.
  assign cnt_inc = st.count + gpc_pkg::COUNT_ONE;

  // One set of comparators per channel against the stored values.
  for (genvar n = 0; n < gpc_pkg::CHANNELS; n++)
  begin : g_chan
    // Channel that lights at the first pulse of a cycle.
    assign chan_lit[n]     = gray_of(st.gray, n) != gpc_pkg::GRAY_OFF;
    // Channel whose value equals the count as it stands.
    assign chan_hit_now[n] = gray_of(st.gray, n) == st.count;
    // Channel whose value equals the count after this pulse.
    assign chan_hit_inc[n] = gray_of(st.gray, n) == cnt_inc;
  end

  // Pin synchronisers.
  // Pin levels reach the engine two clocks late, and the state register adds one
  // more clock, so the outputs answer the count and blanking pins three clocks after they change.
  gpc_sync u_sync_gclk (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_pwm_count_clock),
    .o_sync  (gclk_s)
  );

  gpc_sync u_sync_blank (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_blank),
    .o_sync  (blank_s)
  );

  gpc_sync u_sync_latch (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_async (i_latch_strobe),
    .o_sync  (latch_s)
  );

  // Next-state logic for counter, grayscale store and outputs.
  always_comb
  begin
    logic gclk_rise;
    logic blank_eff;
    // A count pulse is a rising edge of the synchronised count clock.
    gclk_rise       = gclk_s && !st.gclk_q;
    // Until the synchronisers have filled after reset their zeros are not the
    // pin's level, so the engine counts itself blanked; a count pin already high
    // at reset release can then not start a cycle under a raised blanking pin.
    blank_eff       = blank_s || !st.settle[gpc_pkg::SYNC_STAGES-1];
    next_st         = st;
    next_st.gclk_q  = gclk_s;
    next_st.latch_q = latch_s;
    next_st.settle  = {st.settle[gpc_pkg::SYNC_STAGES-2:0], 1'b1};
    // latch load
    // The new values take part in the compares from the next clock on.
    if (latch_s && !st.latch_q)
    begin
      next_st.gray = i_channel_gray_value;
    end
    if (blank_eff)
    begin
      // Blanking wins over any count pulse that falls in the same clock.
      // immediate clear
      next_st.phase = gpc_pkg::GPC_BLANKED;
      next_st.count = gpc_pkg::COUNT_ZERO;
      next_st.sink  = gpc_pkg::OUTPUTS_OFF;
      next_st.done  = 1'b0;
    end
    else
    begin
      unique case (st.phase)
        // One idle clock with blanking low arms the engine for the first pulse.
        // cycle start
        gpc_pkg::GPC_BLANKED:
        begin
          next_st.phase = gpc_pkg::GPC_ARMED;
          next_st.count = gpc_pkg::COUNT_ZERO;
        end
        gpc_pkg::GPC_ARMED:
        begin
          if (gclk_rise)
          begin
            next_st.phase = gpc_pkg::GPC_COUNTING;
            next_st.count = cnt_inc;
            // A value of one lights and ends in the same step, so it never shows.
            next_st.sink  = chan_lit & ~chan_hit_inc;
          end
        end
        gpc_pkg::GPC_COUNTING:
        begin
          if (gclk_rise)
          begin
            next_st.count = cnt_inc;
            next_st.sink  = st.sink & ~chan_hit_inc;
            if (cnt_inc == gpc_pkg::COUNT_LAST)
            begin
              // stop at top
              // A channel latched below the running count has no compare end; this forced off ends it.
              next_st.phase = gpc_pkg::GPC_DONE;
              next_st.sink  = gpc_pkg::OUTPUTS_OFF;
              next_st.done  = 1'b1;
            end
          end
          else
          begin
            // compare off
            // Without a pulse the standing count still ends a channel whose value
            // was just latched equal to it.
            next_st.sink = st.sink & ~chan_hit_now;
          end
        end
        // Further pulses are ignored until blanking clears the counter.
        gpc_pkg::GPC_DONE:
        begin
          next_st.sink = gpc_pkg::OUTPUTS_OFF;
        end
      endcase
    end
  end

  // State register with synchronous reset and clock enable.
  // A low enable freezes the whole state, synchronisers included, so pin events
  // that come and go while frozen are lost.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st.phase   <= gpc_pkg::GPC_BLANKED;
      st.gclk_q  <= 1'b0;
      st.latch_q <= 1'b0;
      st.settle  <= '0;
      st.count   <= gpc_pkg::COUNT_ZERO;
      st.gray    <= '0;
      st.sink    <= gpc_pkg::OUTPUTS_OFF;
      st.done    <= 1'b0;
    end
    else if (i_ce)
      st <= next_st;
  end

  // Outputs come straight from the state register.
  assign o_channel_sink_output = st.sink;
  assign o_gray_count          = st.count;
  assign o_cycle_done          = st.done;

endmodule // gpc_engine

// File: tb/gpc_engine_monitor.sv
`timescale 1ns/1ps
module gpc_engine_monitor (
  // Clock and reset.
  input wire logic         i_clk,
  input wire logic         i_rst_n,
  // Pins from the display controller.
  input wire logic         i_pwm_count_clock,
  input wire logic         i_blank,
  input wire logic [191:0] i_channel_gray_value,
  // Engine outputs.
  input wire logic [15:0]  o_channel_sink_output,
  input wire logic [11:0]  o_gray_count,
  input wire logic         o_cycle_done
);
  logic [15:0] big, eq;
  // Masks of channels above one and of channels equal to the count.
  always_comb
  begin
    for (int n = 0; n < 16; n++)
    begin
      big[n] = i_channel_gray_value[12*n+:12] > 12'h001;
      eq[n] = i_channel_gray_value[12*n+:12] == o_gray_count;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_blank_clear: assert property ($rose(i_blank) |-> ##4 o_gray_count == 12'h000)
    else $error("count kept after blank");
  chk_blank_idle: assert property (i_blank [*4] |-> o_channel_sink_output == 16'h0000
    && o_gray_count == 12'h000) else $error("blanked outputs active");
  chk_count_step: assert property ($changed(o_gray_count) |-> o_gray_count == 12'h000
    || o_gray_count == $past(o_gray_count) + 12'h001) else $error("count jumped");
  chk_count_cause: assert property (o_gray_count != 12'h000
    && o_gray_count == $past(o_gray_count) + 12'h001
    |-> $past(i_pwm_count_clock, 3) && !$past(i_blank, 3)) else $error("count without pulse");
  chk_done_last: assert property (o_cycle_done == (o_gray_count == 12'hfff))
    else $error("done flag wrong");
  chk_done_off: assert property (o_cycle_done |-> o_channel_sink_output == 16'h0000)
    else $error("sink on at end");
  chk_sink_on: assert property (o_gray_count == 12'h001 && $past(o_gray_count) == 12'h000
    |-> o_channel_sink_output == big) else $error("wrong sinks on");
  chk_sink_off: assert property ($changed(o_gray_count) && o_gray_count > 12'h001
    |-> (o_channel_sink_output & eq) == 16'h0000) else $error("sink not off");
  // Main scenarios reached.
  cover property (o_cycle_done);
  cover property ($rose(i_blank) && o_gray_count == 12'h005);
  cover property ($fell(o_channel_sink_output[1]));
endmodule // gpc_engine_monitor
bind gpc_engine gpc_engine_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_pwm_count_clock(i_pwm_count_clock), .i_blank(i_blank),
  .i_channel_gray_value(i_channel_gray_value), .o_channel_sink_output(o_channel_sink_output),
  .o_gray_count(o_gray_count), .o_cycle_done(o_cycle_done));

// File: tb/gpc_ctrl_model.sv
`timescale 1ns/1ps
module gpc_ctrl_model (
  // Run request and pulse count.
  input  wire logic        i_clk, i_run,
  input  wire logic [12:0] i_pulses,
  // Pins to the engine and a busy flag.
  output logic             o_pwm_count_clock = 1'b0, o_blank = 1'b1, o_busy
);
  logic [12:0] left = 13'h0000;
  logic [1:0]  ph = 2'h0;
  assign o_busy = i_run && left != 13'h0000;
  // blanking and pulses
  // Blank while idle, else one count pulse, two clocks high, per four-clock step until the burst is spent.
  always_ff @(posedge i_clk)
  begin
    o_blank <= !i_run;
    ph <= i_run ? ph + 2'h1 : 2'h0;
    o_pwm_count_clock <= o_busy && ph[1];
    if (!i_run) left <= i_pulses;
    else if (o_busy && ph == 2'h3) left <= left - 13'h0001;
  end
endmodule // gpc_ctrl_model

// File: tb/test_grayscale_pwm_counter.sv
`timescale 1ns/1ps
module test_grayscale_pwm_counter;
  logic         i_clk = 1'b0, i_rst_n = 1'b0, run = 1'b0, latch = 1'b0, pwm, blank, busy, done;
  logic [12:0]  pulses = 13'h0000;
  logic [191:0] gray = '0;
  logic [15:0]  sink;
  logic [11:0]  count;
  int           mismatches = 0, num_checks = 0;
  // Free-running clock.
  initial forever #10 i_clk = ~i_clk;
  gpc_ctrl_model u_ctrl (.i_clk(i_clk), .i_run(run), .i_pulses(pulses),
    .o_pwm_count_clock(pwm), .o_blank(blank), .o_busy(busy));
  gpc_engine uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_pwm_count_clock(pwm),
    .i_blank(blank), .i_latch_strobe(latch), .i_channel_gray_value(gray),
    .o_channel_sink_output(sink), .o_gray_count(count), .o_cycle_done(done));
  // Compares one value and reports a mismatch.
  task check(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Prints the verdict and ends the run.
  task close_out();
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Runs a burst of count pulses, then lets the outputs settle.
  task burst(input logic [12:0] n);
    @(posedge i_clk) pulses <= n;
    @(posedge i_clk) run <= 1'b1;
    repeat (2) @(posedge i_clk);
    for (int k = 0; k < 20000 && busy !== 1'b0; k++) @(posedge i_clk);
    check("busy", 16'h0000, {15'h0, busy});
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // Raises blanking and waits for it to take effect.
  task stop();
    @(posedge i_clk) run <= 1'b0;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // Latches values 3n while blanked, counts five, then blanks early.
  task t_partial();
    @(negedge i_clk);
    check("sink", 16'h0000, sink);
    @(posedge i_clk);
    for (int n = 0; n < 16; n++) gray[12*n+:12] <= 12'(3 * n);
    latch <= 1'b1;
    repeat (4) @(posedge i_clk);
    latch <= 1'b0;
    burst(13'h0005);
    check("count", 16'h0005, {4'h0, count});
    check("sink", 16'hfffc, sink);
    stop();
    check("count", 16'h0000, {4'h0, count});
    check("sink", 16'h0000, sink);
  endtask
  // Runs past the last count; extra pulses are ignored until blanking.
  task t_full();
    burst(13'h1004);
    check("count", 16'h0fff, {4'h0, count});
    check("done", 16'h0001, {15'h0, done});
    check("sink", 16'h0000, sink);
    stop();
    check("count", 16'h0000, {4'h0, count});
    check("done", 16'h0000, {15'h0, done});
  endtask
  // Reset, then the scenarios.
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_partial();
    t_full();
    close_out();
  end
  // Watchdog against a hang.
  initial
  begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    close_out();
  end
endmodule // test_grayscale_pwm_counter
